/* asp_cfg.svh */
// offsets, field positions, reset values and timing counts of the angle sensor spi port
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

`define ASP_A_EXT_WRITE_CMD_STATUS_GO   6'h01
`define ASP_A_EXT_READ_CMD_STATUS_GO   6'h09
`define ASP_A_CTRL_KEY  6'h1e
`define ASP_A_WARN_CLR  6'h23

`define ASP_IX_EXT_WRITE_CMD_STATUS     4'h0
`define ASP_IX_EWA      4'h1
`define ASP_IX_EXT_WRITE_DATA_HIGH     4'h2
`define ASP_IX_EXT_WRITE_DATA_LOW     4'h3
`define ASP_IX_EXT_READ_CMD_STATUS     4'h4
`define ASP_IX_ERA      4'h5
`define ASP_IX_EXT_READ_DATA_HIGH     4'h6
`define ASP_IX_EXT_READ_DATA_LOW     4'h7
`define ASP_IX_CTRL     4'hf

`define ASP_W_STA       5'h10
`define ASP_W_WARN      5'h11
`define ASP_W_TDH       5'h14
`define ASP_W_TDL       5'h15

`define ASP_KEY         8'h46
`define ASP_CMD_LOAD    4'h3
`define ASP_CMD_ZERO    4'h1
`define ASP_SPO_BIT     7
`define ASP_GO_BIT      0
`define ASP_NV_BIT      7

`define ASP_LEN_STD     5'h10
`define ASP_LEN_S17     5'h11
`define ASP_LEN_CRC     5'h14
`define ASP_CNT_MAX     5'h1f
`define ASP_CRC_INIT    4'hf
`define ASP_RST_WORD    16'h0000

`define ASP_CLK_MHZ      50
`define ASP_SCLK_MAX_MHZ 10
`define ASP_SCLK_MIN_CYC ((`ASP_CLK_MHZ + `ASP_SCLK_MAX_MHZ - 1) / `ASP_SCLK_MAX_MHZ)

`endif

/* asp_pkg.sv */
// types of the angle sensor spi port
package asp_pkg;
  typedef enum logic [2:0] {
    EXT_IDLE = 3'b001,
    EXT_WR   = 3'b010,
    EXT_RD   = 3'b100
  } asp_ext_type;

  typedef enum logic [3:0] {
    OWN_MAN  = 4'b0001,
    OWN_SPI  = 4'b0010,
    OWN_PWM  = 4'b0100,
    OWN_SENT = 4'b1000
  } asp_owner_type;
endpackage

/* asp_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module asp_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] init_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s1_q <= init_i;
      s2_q <= init_i;
      s3_q <= init_i;
    end else if (en_i) begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // init_i lets chip select idle high; taken one bit at a time once stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        q_o[i] <= init_i[i];
      end else if (en_i) begin
        if (s2_q[i] == s3_q[i]) begin
          q_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // asp_sync
`default_nettype wire

/* asp_spi_port.sv */
// spi peripheral port with primary registers, turns-delta load and output arbitration
`timescale 1ns/1ps
`default_nettype none
`include "asp_cfg.svh"
// Function
// - command_code_a command zeroes the turns counter, or loads the sensed angle under init 10/11
// - turns-delta never written directly over spi
// - code 0x03 then key 0x46 loads
// - init 00/01 copies staged value verbatim
// - init 10/11 snaps value to sensed angle
// - supply-protocol disable ignores supply commands
// - lock blocks nonvolatile writes from both ports
// - output pin ownership follows fixed priority
// - extended memory reached only through primary registers
// - write side: address, data words, cmd/status
// - read side: address, result words, cmd/status
// - peripheral only, serial clock up to 10 MHz
// - frames of 16, 17 or 20 clocks
// - twenty-clock frame carries 4-bit crc
// - wrong clock count sets interface error
// - sample on rise, act at select release
// - write frame returns previous read or zeroes
// - seventeen-clock mode accepts one trailing clock
// - miso launched ahead of host sampling edge
// - odd address read zeroes upper byte
// - crc x^4+x+1, preset ones, msb first
module asp_spi_port (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   en_i,
  input  wire logic                   sclk_i,
  input  wire logic                   csn_i,
  input  wire logic                   mosi_i,
  output logic                        miso_o,
  output logic                        miso_oe_o,
  input  wire logic                   seventeen_clock_mode_i,
  input  wire logic [1:0]             turns_init_i,
  input  wire logic                   angle_ok_flag_i,
  input  wire logic [11:0]            angle_i,
  input  wire logic                   angle_step_valid_i,
  input  wire logic [20:0]            angle_step_i,
  input  wire logic                   eeprom_lock_i,
  input  wire logic                   supply_protocol_disable_i,
  input  wire logic                   sup_cmd_valid_i,
  input  wire logic                   sup_cmd_nv_write_i,
  output logic                        sup_cmd_accept_o,
  input  wire logic                   manchester_active_i,
  input  wire logic                   pwm_output_enable_i,
  input  wire logic                   sent_enable_i,
  output asp_pkg::asp_owner_type      shared_output_pin_owner_o,
  output logic                        ext_wr_req_o,
  output logic                        ext_rd_req_o,
  output logic [7:0]                  ext_addr_o,
  output logic [31:0]                 ext_wdata_o,
  input  wire logic                   ext_done_i,
  input  wire logic [31:0]            ext_rdata_i,
  output logic                        interface_error_warning_o,
  output logic [20:0]                 turns_delta_o
);
  import asp_pkg::*;

  logic        sclk_s;
  logic        csn_s;
  logic        mosi_s;
  logic        sclk_p_q;
  logic        csn_p_q;
  logic [4:0]  cnt_q;
  logic [19:0] rx_q;
  logic [19:0] tx_q;
  logic [5:0]  sel_q;
  logic        rd_valid_q;
  logic        ierr_q;
  logic [15:0] regs_q [16];
  logic [15:0] rd_word;
  logic [15:0] payload;
  logic [20:0] staged;
  logic [11:0] snap_diff;
  logic [20:0] td_q;
  asp_ext_type st_q;
  logic        wr_done_q;
  logic        wr_ref_q;
  logic        rd_done_q;
  logic        sclk_rise;
  logic        cs_fall;
  logic        cs_rise;
  logic        len_ok;
  logic        frame_ok;
  logic        wr_hit;
  logic [5:0]  wa;
  logic [7:0]  wd;
  logic        cmd_go;
  logic        load_go;
  logic        zero_go;
  logic        ew_go;
  logic        er_go;
  logic        nv_blocked;
  logic        rd_load;
  logic        warn_clr;

  // csn resets high straight from init_i; a pin change reaches the outputs four cycles later
  asp_sync #(.W(3)) u_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .en_i   (en_i),
    .d_i    ({sclk_i, csn_i, mosi_i}),
    .init_i (3'h2),
    .q_o    ({sclk_s, csn_s, mosi_s})
  );

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sclk_p_q <= 1'b0;
      csn_p_q  <= 1'b1;
    end else if (en_i) begin
      sclk_p_q <= sclk_s;
      csn_p_q  <= csn_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_p_q & ~csn_s;
  assign cs_fall   = ~csn_s & csn_p_q;
  assign cs_rise   = csn_s & ~csn_p_q;

  function automatic logic [3:0] crc4(input logic [15:0] d);
    logic [3:0] c;
    logic       inv;
    c = `ASP_CRC_INIT;
    for (int k = 15; k >= 0; k--) begin
      inv = d[k] ^ c[3];
      c   = {c[2], c[1], c[0] ^ inv, inv};
    end
    return c;
  endfunction

  // frame length check and payload alignment
  always_comb begin
    if (seventeen_clock_mode_i) begin
      len_ok = (cnt_q == `ASP_LEN_S17);
    end else begin
      len_ok = (cnt_q == `ASP_LEN_STD) || (cnt_q == `ASP_LEN_CRC);
    end
    if (cnt_q == `ASP_LEN_S17) begin
      payload = rx_q[16:1];
    end else if (cnt_q == `ASP_LEN_CRC) begin
      payload = rx_q[19:4]; // incoming crc bits are not checked
    end else begin
      payload = rx_q[15:0];
    end
  end

  assign frame_ok = en_i & cs_rise & len_ok & ~payload[15];
  assign wr_hit   = frame_ok & payload[14];
  assign wa       = payload[13:8];
  assign wd       = payload[7:0];
  assign warn_clr = wr_hit && (wa == `ASP_A_WARN_CLR) && wd[0];

  // shift in on sclk rise, act only at select release
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= 5'h00;
      rx_q  <= 20'h00000;
    end else if (en_i) begin
      if (cs_fall) begin
        cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        rx_q <= {rx_q[18:0], mosi_s};
        if (cnt_q != `ASP_CNT_MAX) begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

  // the core sees the sclk fall too late to launch on it, so the
  // next bit leaves once the core sees the sampling rise and is stable by the next rise
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tx_q <= 20'h00000;
    end else if (en_i) begin
      if (cs_fall) begin
        tx_q <= rd_valid_q ? {rd_word, crc4(rd_word)} : 20'h00000;
      end else if (sclk_rise) begin
        tx_q <= {tx_q[18:0], 1'b0};
      end
    end
  end

  assign miso_o    = tx_q[19];
  assign miso_oe_o = ~csn_s;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sel_q      <= 6'h00;
      rd_valid_q <= 1'b0;
    end else if (frame_ok && !payload[14]) begin
      sel_q      <= wa;
      rd_valid_q <= 1'b1;
    end
  end

  // hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ierr_q <= 1'b0;
    end else if (en_i) begin
      if (cs_rise && !len_ok) begin
        ierr_q <= 1'b1;
      end else if (warn_clr) begin
        ierr_q <= 1'b0;
      end
    end
  end

  assign interface_error_warning_o = ierr_q;

  // primary register storage, one byte per frame
  for (genvar i = 0; i < 16; i++) begin : g_reg
    localparam logic [3:0] IX = 4'(i);
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        regs_q[i] <= `ASP_RST_WORD;
      end else if (IX == `ASP_IX_EXT_READ_DATA_HIGH || IX == `ASP_IX_EXT_READ_DATA_LOW) begin
        if (rd_load) begin
          regs_q[i] <= (IX == `ASP_IX_EXT_READ_DATA_HIGH) ? ext_rdata_i[31:16] : ext_rdata_i[15:0];
        end
      end else if (wr_hit && !wa[5] && wa[4:1] == IX) begin
        if (wa[0]) begin
          regs_q[i][7:0] <= wd;
        end else if (IX != `ASP_IX_CTRL) begin
          regs_q[i][15:8] <= wd;
        end
      end
    end
  end

  // read data of the last read command, snapshotted at frame start
  always_comb begin
    rd_word = 16'h0000;
    if (!sel_q[5]) begin
      rd_word = regs_q[sel_q[4:1]];
      if (sel_q[4:1] == `ASP_IX_EXT_WRITE_CMD_STATUS) begin
        rd_word = {13'h0000, wr_ref_q, wr_done_q, st_q == EXT_WR};
      end else if (sel_q[4:1] == `ASP_IX_EXT_READ_CMD_STATUS) begin
        rd_word = {14'h0000, rd_done_q, st_q == EXT_RD};
      end else if (sel_q[4:1] == `ASP_IX_CTRL) begin
        rd_word = {8'h00, regs_q[sel_q[4:1]][7:0]};
      end
    end else begin
      case (sel_q[5:1])
        `ASP_W_STA:  rd_word = {15'h0000, angle_ok_flag_i};
        `ASP_W_WARN: rd_word = {15'h0000, ierr_q};
        `ASP_W_TDH:  rd_word = {11'h000, td_q[20:16]};
        `ASP_W_TDL:  rd_word = td_q[15:0];
        default:     rd_word = 16'h0000;
      endcase
    end
    if (sel_q[0]) begin
      rd_word = {8'h00, rd_word[7:0]};
    end
    if (!rd_valid_q) begin
      rd_word = 16'h0000;
    end
  end

  // command_code_a commands: key byte at 0x1e fires the code already held at 0x1f and is not stored
  assign cmd_go  = wr_hit && (wa == `ASP_A_CTRL_KEY) && (wd == `ASP_KEY);
  assign load_go = cmd_go && (regs_q[`ASP_IX_CTRL][3:0] == `ASP_CMD_LOAD);
  assign zero_go = cmd_go && (regs_q[`ASP_IX_CTRL][3:0] == `ASP_CMD_ZERO);
  assign staged  = {regs_q[`ASP_IX_EXT_WRITE_DATA_HIGH][4:0], regs_q[`ASP_IX_EXT_WRITE_DATA_LOW]};
  assign snap_diff = angle_i - staged[11:0];

  // the loaded value is not checked against angle ok; that is the host's job
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      td_q <= 21'h000000;
    end else if (en_i) begin
      if (load_go && turns_init_i[1]) begin
        td_q <= staged + {{9{snap_diff[11]}}, snap_diff};
      end else if (load_go) begin
        td_q <= staged;
      end else if (zero_go) begin
        td_q <= turns_init_i[1] ? {9'h000, angle_i} : 21'h000000;
      end else if (angle_step_valid_i) begin
        td_q <= td_q + angle_step_i;
      end
    end
  end

  assign turns_delta_o = td_q;

  // indirect extended access engine
  assign ew_go      = wr_hit && (wa == `ASP_A_EXT_WRITE_CMD_STATUS_GO) && wd[`ASP_GO_BIT];
  assign er_go      = wr_hit && (wa == `ASP_A_EXT_READ_CMD_STATUS_GO) && wd[`ASP_GO_BIT];
  assign nv_blocked = eeprom_lock_i && !regs_q[`ASP_IX_EWA][`ASP_NV_BIT];
  assign rd_load    = en_i && (st_q == EXT_RD) && ext_done_i;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q        <= EXT_IDLE;
      wr_done_q   <= 1'b0;
      wr_ref_q    <= 1'b0;
      rd_done_q   <= 1'b0;
      ext_addr_o  <= 8'h00;
      ext_wdata_o <= 32'h00000000;
    end else if (en_i) begin
      unique case (st_q)
        EXT_IDLE: begin
          if (ew_go && nv_blocked) begin
            wr_ref_q <= 1'b1;
          end else if (ew_go) begin
            st_q        <= EXT_WR;
            wr_ref_q    <= 1'b0;
            wr_done_q   <= 1'b0;
            ext_addr_o  <= regs_q[`ASP_IX_EWA][7:0];
            ext_wdata_o <= {regs_q[`ASP_IX_EXT_WRITE_DATA_HIGH], regs_q[`ASP_IX_EXT_WRITE_DATA_LOW]};
          end else if (er_go) begin
            st_q       <= EXT_RD;
            rd_done_q  <= 1'b0;
            ext_addr_o <= regs_q[`ASP_IX_ERA][7:0];
          end
        end
        EXT_WR: begin
          if (ext_done_i) begin
            st_q      <= EXT_IDLE;
            wr_done_q <= 1'b1;
          end
        end
        EXT_RD: begin
          if (ext_done_i) begin
            st_q      <= EXT_IDLE;
            rd_done_q <= 1'b1;
          end
        end
        default: st_q <= EXT_IDLE;
      endcase
    end
  end

  assign ext_wr_req_o = (st_q == EXT_WR);
  assign ext_rd_req_o = (st_q == EXT_RD);

  assign sup_cmd_accept_o = sup_cmd_valid_i & ~supply_protocol_disable_i
                          & ~(sup_cmd_nv_write_i & eeprom_lock_i);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      shared_output_pin_owner_o <= OWN_SPI;
    end else if (en_i) begin
      if (manchester_active_i) begin
        shared_output_pin_owner_o <= OWN_MAN;
      end else if (regs_q[`ASP_IX_CTRL][`ASP_SPO_BIT]) begin
        shared_output_pin_owner_o <= OWN_SPI;
      end else if (pwm_output_enable_i) begin
        shared_output_pin_owner_o <= OWN_PWM;
      end else if (sent_enable_i) begin
        shared_output_pin_owner_o <= OWN_SENT;
      end else begin
        shared_output_pin_owner_o <= OWN_SPI;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_bad_frame;
    en_i && cs_rise && !len_ok;
  endsequence

  sequence s_load_copy;
    load_go && !turns_init_i[1];
  endsequence

  a_len_error_set: assert property (s_bad_frame |=> ierr_q)
    else $error("bad frame length did not raise the warning");
  a_good_len_quiet: assert property (en_i && cs_rise && len_ok && !ierr_q |=> !ierr_q)
    else $error("good frame length raised the warning");
  a_turns_hold: assert property (en_i && !load_go && !zero_go && !angle_step_valid_i
    |=> $stable(td_q))
    else $error("turns delta changed without load, command or step");
  a_turns_copy: assert property (s_load_copy |=> td_q == $past(staged))
    else $error("staged value not copied verbatim");
  a_turns_snap: assert property (load_go && turns_init_i[1]
    |=> td_q[11:0] == $past(angle_i))
    else $error("snapped value does not match sensed angle");
  a_turns_zero: assert property (zero_go && !turns_init_i[1] |=> td_q == 21'h000000)
    else $error("turns counter not zeroed");
  a_owner_manch: assert property (en_i && manchester_active_i |=> shared_output_pin_owner_o == OWN_MAN)
    else $error("supply protocol did not take the output pin");
  a_sup_ignored: assert property (supply_protocol_disable_i |-> !sup_cmd_accept_o)
    else $error("supply command accepted while disabled");
  a_nv_locked: assert property (ew_go && nv_blocked && st_q == EXT_IDLE
    |=> !ext_wr_req_o && wr_ref_q)
    else $error("locked nonvolatile write was issued");
  a_miso_zero: assert property (en_i && cs_fall && !rd_valid_q |=> tx_q == 20'h00000)
    else $error("miso not zero before any read");
  a_miso_crc: assert property (en_i && cs_fall && rd_valid_q |=> tx_q[3:0] == crc4(tx_q[19:4]))
    else $error("outgoing crc wrong");
endmodule // asp_spi_port
`default_nettype wire

/* asp_host.sv */
// spi controller model that drives frames into the port and samples miso
`timescale 1ns/1ps
`default_nettype none
module asp_host (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [4:0]  len_i,
  input  wire logic [19:0] tx_i,
  input  wire logic        miso_i,
  output logic             sclk_o,
  output logic             csn_o,
  output logic             mosi_o,
  output logic             done_o,
  output logic [19:0]      rx_o
);
  initial begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    mosi_o = 1'b0;
    done_o = 1'b0;
    rx_o   = '0;
  end
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // mode 0, 8 clk per bit: 160 ns, under the 10 mhz ceiling
  always @(posedge clk_i) begin
    if (go_i) begin
      rx_o  <= '0;
      csn_o <= 1'b0;
      ticks(6);
      for (int i = 0; i < len_i; i++) begin
        mosi_o <= tx_i[19-i];
        ticks(4);
        sclk_o <= 1'b1;
        rx_o   <= {rx_o[18:0], miso_i};
        ticks(4);
        sclk_o <= 1'b0;
      end
      ticks(4);
      csn_o  <= 1'b1;
      // released line flips so a stale bit never looks valid
      mosi_o <= ~mosi_o;
      ticks(12);
      done_o <= 1'b1;
      ticks(1);
      done_o <= 1'b0;
    end
  end
endmodule // asp_host
`default_nettype wire

/* tb_top.sv */
// self-checking bench of the angle sensor spi port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asp_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic go = 1'b0, done, s17 = 1'b0, vld = 1'b0, nvw = 1'b0, lck = 1'b0, dis = 1'b0;
  logic man = 1'b0, pwm = 1'b0, sen = 1'b0, stv = 1'b0, aok = 1'b1, xdn = 1'b0;
  logic en = 1'b1;
  logic sclk, csn, mosi, miso, wrq, rrq;
  logic [1:0]  tin = 2'b00;
  logic [4:0]  len = 5'h10, wl = 5'h10;
  logic [11:0] ang = 12'h000, df;
  logic [19:0] tx = '0, rx;
  logic [20:0] stp = '0, st, tdo;
  logic [31:0] xrd = '0, xwd, r;
  logic [7:0]  xad;
  logic [15:0] d, e;
  logic [20:0] ent;
  logic [20:0] eq[$];
  asp_owner_type own;
  int seed = 73;
  int n_errors = 0;
  int comparisons = 0;
  int lens[5] = '{15, 18, 20, 16, 17};
  logic [1:0] lw[5] = '{2'b01, 2'b01, 2'b00, 2'b11, 2'b10};
  logic oe, acc, warn;
  initial forever #10 clk_i = ~clk_i;
  asp_host host (.clk_i(clk_i), .go_i(go), .len_i(len), .tx_i(tx), .miso_i(miso),
    .sclk_o(sclk), .csn_o(csn), .mosi_o(mosi), .done_o(done), .rx_o(rx));
  asp_spi_port DUT (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en), .sclk_i(sclk),
    .csn_i(csn), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(oe),
    .seventeen_clock_mode_i(s17), .turns_init_i(tin), .angle_ok_flag_i(aok),
    .angle_i(ang), .angle_step_valid_i(stv), .angle_step_i(stp), .eeprom_lock_i(lck),
    .supply_protocol_disable_i(dis), .sup_cmd_valid_i(vld), .sup_cmd_nv_write_i(nvw),
    .sup_cmd_accept_o(acc), .manchester_active_i(man), .pwm_output_enable_i(pwm),
    .sent_enable_i(sen), .shared_output_pin_owner_o(own), .ext_wr_req_o(wrq), .ext_rd_req_o(rrq),
    .ext_addr_o(xad), .ext_wdata_o(xwd), .ext_done_i(xdn), .ext_rdata_i(xrd),
    .interface_error_warning_o(warn), .turns_delta_o(tdo));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // monitor: each finished frame takes the oldest note
  always @(posedge clk_i) begin
    if (done === 1'b1 && eq.size() > 0) begin
      ent = eq.pop_front();
      if (ent[20]) chk(rx, ent[19:0]);
    end
  end
  function automatic logic [3:0] crc4(input logic [15:0] v);
    logic [3:0] c;
    logic b;
    c = 4'hf;
    for (int i = 15; i >= 0; i--) begin
      b = v[i] ^ c[3];
      c = {c[2], c[1], c[0] ^ b, b};
    end
    return c;
  endfunction
  task automatic xfer(input logic [4:0] l, input logic [15:0] w, input logic c,
                      input logic [19:0] x);
    int k;
    len <= l;
    tx  <= {w, 4'h0};
    go  <= 1'b1;
    eq.push_back({c, x});
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 1000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 1000) n_errors++;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    xfer(wl, {2'b01, a, v}, 1'b0, '0);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] x);
    xfer(wl, {2'b00, a, 8'h00}, 1'b0, '0);
    xfer(wl, {2'b00, a, 8'h00}, 1'b1, {4'h0, x});
  endtask
  // host loads only with angle ok held high
  task automatic ld(input logic [3:0] c);
    wr(6'h1f, {4'h0, c});
    wr(6'h1e, 8'h46);
  endtask
  task automatic pulse;
    xdn <= 1'b1;
    @(posedge clk_i);
    xdn <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    #800000;
    n_errors++;
    $display("watchdog expired");
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(oe, 0);
    chk(own, OWN_SPI);
    chk({warn, tdo}, 0);
    d = $random(seed);
    e = $random(seed);
    xfer(16, {2'b01, 6'h04, d[15:8]}, 1'b1, 20'h0);
    wr(6'h05, d[7:0]);
    wr(6'h06, e[15:8]);
    wr(6'h07, e[7:0]);
    rd(6'h04, d);
    rd(6'h07, {8'h00, e[7:0]});
    xfer(20, {2'b00, 6'h06, 8'h00}, 1'b0, '0);
    xfer(20, {2'b00, 6'h06, 8'h00}, 1'b1, {e, crc4(e)});
    rd(6'h20, 16'h0001);
    $display("test registers done");
    st = {d[4:0], e};
    ld(4'h3);
    chk(tdo, st);
    stp <= 21'h1ffff0;
    stv <= 1'b1;
    @(posedge clk_i);
    stv <= 1'b0;
    repeat (2) @(posedge clk_i);
    st = st + 21'h1ffff0;
    chk(tdo, st);
    en <= 1'b0;
    stv <= 1'b1;
    @(posedge clk_i);
    stv <= 1'b0;
    en <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(tdo, st);
    wr(6'h2a, 8'hff);
    wr(6'h2b, 8'hff);
    chk(tdo, st);
    ld(4'h1);
    chk(tdo, 0);
    tin <= 2'b10;
    ang <= $random(seed);
    st = {d[4:0], e};
    ld(4'h3);
    df = ang - st[11:0];
    chk(tdo, st + {{9{df[11]}}, df});
    st = st + {{9{df[11]}}, df};
    rd(6'h2a, st[15:0]);
    rd(6'h28, {11'h000, st[20:16]});
    tin <= 2'b00;
    $display("test turns done");
    for (int i = 0; i < 5; i++) begin
      wr(6'h23, 8'h01);
      chk(warn, 0);
      s17 <= lw[i][1];
      wl = lw[i][1] ? 5'h11 : 5'h10;
      xfer(lens[i], {2'b00, 6'h20, 8'h00}, 1'b0, '0);
      chk(warn, lw[i][0]);
    end
    wr(6'h23, 8'h01);
    s17 <= 1'b0;
    wl = 5'h10;
    $display("test lengths done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      {vld, nvw, lck, dis} <= i[3:0];
      @(negedge clk_i);
      chk(acc, i[3] & !i[0] & !(i[2] & i[1]));
    end
    for (int i = 0; i < 8; i++) begin
      {man, pwm, sen} <= i[2:0];
      repeat (3) @(posedge clk_i);
      chk(own, i[2] ? OWN_MAN : i[1] ? OWN_PWM : i[0] ? OWN_SENT : OWN_SPI);
    end
    {man, pwm, sen} <= 3'b010;
    wr(6'h1f, 8'h80);
    chk(own, OWN_SPI);
    man <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(own, OWN_MAN);
    {man, pwm, lck} <= 3'b000;
    $display("test arbitration done");
    wr(6'h03, 8'h85);
    wr(6'h01, 8'h01);
    chk({wrq, xad}, {1'b1, 8'h85});
    chk(xwd, {d, e});
    pulse();
    chk(wrq, 0);
    rd(6'h00, 16'h0002);
    lck <= 1'b1;
    wr(6'h03, 8'h05);
    wr(6'h01, 8'h01);
    chk(wrq, 0);
    rd(6'h00, 16'h0006);
    lck <= 1'b0;
    wr(6'h0b, 8'h12);
    wr(6'h09, 8'h01);
    chk({rrq, xad}, {1'b1, 8'h12});
    r = $random(seed);
    xrd <= r;
    pulse();
    rd(6'h08, 16'h0002);
    rd(6'h0c, r[31:16]);
    rd(6'h0e, r[15:0]);
    $display("test extended done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
